// ===== i2c_bus_control_core.sv
// Purpose: i2c bus control core with avalon register slave
// Assumes: bus lines are open drain, sampled by clk through two flops
// Notes: one register access completes one cycle after the request rises
`timescale 1ns/1ns
module i2c_bus_control_core (
    input  wire logic                   clk,
    input  wire logic                   rst,
    input  wire i2c_core_pkg::avs_req_t avs_req,
    output logic [31:0]                 avs_readdata,
    output logic                        avs_waitrequest,
    input  wire logic                   clock_line_io_i,
    input  wire logic                   data_line_io_i,
    output i2c_core_pkg::pin_drv_t      line_drv,
    input  wire i2c_core_pkg::pin_drv_t port_drv,
    output logic                        transfer_interrupt
);
    import i2c_core_pkg::*;

    // state registers
    logic        done_r;         // second cycle of an access
    logic        imode_r;        // interface mode
    logic        mst_r;          // master select
    logic        trx_r;          // transmit select
    logic        busy_r;         // bus busy status
    logic        pend_r;         // pending flag
    logic        lost_r;         // arbitration lost
    logic        aas_r;          // addressed as slave
    logic        lastb_r;        // last sampled data bit
    logic        arm_r;          // soft reset armed
    logic        first_r;        // address word in progress
    logic        irq_r;          // interrupt pulse
    logic [7:0]  sh_r;           // shift register / data buffer
    logic [3:0]  pos_r;          // bit position in word
    logic [8:0]  cnt_r;          // timing counter
    logic [8:0]  cnt_nxt;
    ctrl_one_t   c1_r;           // control one
    own_addr_t   oa_r;           // own address register
    link_state_t st_r;
    link_state_t st_nxt;
    logic [1:0]  scl_sync_r;     // clock line synchronizer
    logic [1:0]  sda_sync_r;     // data line synchronizer
    logic        scl_d_r;        // delayed synced clock line
    logic        sda_d_r;        // delayed synced data line

    // bus decode
    wire        req_any = avs_req.read | avs_req.write;
    wire        wr_fire = avs_req.write & done_r;
    wire        rd_fire = avs_req.read & done_r;
    wire        hit_c1  = avs_req.address == OFS_CTRL_ONE;
    wire        hit_c2  = avs_req.address == OFS_CTRL_TWO;
    wire        hit_st  = avs_req.address == OFS_STATUS;
    wire        hit_db  = avs_req.address == OFS_DATA_BUF;
    wire        hit_oa  = avs_req.address == OFS_OWN_ADDR;
    wire        wr_c1   = wr_fire & hit_c1;
    wire        wr_c2   = wr_fire & hit_c2;
    wire        wr_db   = wr_fire & hit_db;
    wire        rd_db   = rd_fire & hit_db;
    wire        wr_oa   = wr_fire & hit_oa;
    ctrl_two_t  c2w;
    assign c2w = ctrl_two_t'(avs_req.writedata[7:0]);
    // control two bits other than mode only land in interface mode
    wire        c2_live = wr_c2 & imode_r;
    assign avs_waitrequest = req_any & ~done_r;

    // synced lines and bus conditions
    wire scl_s     = scl_sync_r[1];
    wire sda_s     = sda_sync_r[1];
    wire scl_rise  = imode_r & scl_s & ~scl_d_r;
    wire scl_fall  = imode_r & ~scl_s & scl_d_r;
    wire start_det = imode_r & scl_s & scl_d_r & sda_d_r & ~sda_s;
    wire stop_det  = imode_r & scl_s & scl_d_r & ~sda_d_r & sda_s;

    // serial clock periods
    wire [8:0] t_high = CLK_HIGH_BASE + (CLK_STEP << c1_r.clock_period_select);
    wire [8:0] t_low  = t_high + CLK_LOW_EXTRA;
    wire       hi_end = cnt_r == t_high - 9'h001;
    wire       lo_end = cnt_r == t_low - 9'h001;

    // word geometry: clocks from bit count plus optional acknowledge slot
    wire [3:0] nbits    = (c1_r.bit_count == 3'h0) ? ADDR_WORD_BITS : {1'b0, c1_r.bit_count};
    wire [3:0] last_pos = nbits - 4'h1 + {3'h0, c1_r.handshake_slot_enable};
    wire       in_data  = busy_r & (pos_r < nbits);
    wire       in_ack   = busy_r & c1_r.handshake_slot_enable & (pos_r == nbits);
    wire       engaged  = mst_r | aas_r;
    wire       free_fmt = oa_r.free_format_select;
    wire       tx_low   = in_data & trx_r & engaged & ~lost_r & ~sh_r[7] & (mst_r | ~first_r);
    wire       ack_low  = in_ack & ~lost_r & (first_r ? (aas_r & ~mst_r) : (~trx_r & engaged));

    // own data level differs from the bus at clock rise
    wire lost_set = scl_rise & mst_r & trx_r & in_data & ~tx_low & ~sda_s & (st_r != S_STP_W);

    // slave address recognition on the eighth rise
    wire [7:0] addr_word  = {sh_r[6:0], sda_s};
    wire       addr_match = (addr_word == GEN_CALL_CODE)
                          | (addr_word[7:1] == oa_r.own_slave_address);
    wire       det_ok     = ~c1_r.address_detect_disable & ~free_fmt;
    wire       addr_hit   = scl_rise & busy_r & first_r & (pos_r == POS_ADDR_LAST)
                          & ~mst_r & det_ok & addr_match;
    // master sees acknowledge of its address
    wire       mack       = scl_rise & first_r & mst_r & in_ack & ~sda_s & det_ok;
    // free format flags the slave after its first word
    wire       wend       = scl_fall & busy_r & (pos_r == last_pos);
    wire       aas_ff     = wend & first_r & free_fmt & ~mst_r;
    wire       aas_set    = addr_hit | aas_ff;
    // word end interrupt for master, addressed slave, lost master or free format
    wire       irq        = wend & (mst_r | aas_r | lost_r | free_fmt);

    // software commands
    wire start_go = c2_live & c2w.master_select & c2w.transmit_select & c2w.pending_flag
                  & c2w.bus_busy & ~busy_r & (st_r == S_IDLE);
    wire stop_go  = c2_live & c2w.master_select & c2w.transmit_select & c2w.pending_flag
                  & ~c2w.bus_busy & busy_r;
    // second step of the soft reset
    wire sreset   = c2_live & arm_r & (c2w.soft_reset_field == SWR_FIRE);
    wire pend_set = wr_db | (c2_live & c2w.pending_flag);
    wire trx_hw   = stop_det | lost_set | addr_hit | mack | sreset;

    // line drive; an idle master lets data go so the stop can rise
    wire seq_sda  = st_r inside {S_STA_L, S_STP_L, S_STP_W, S_STP_H};
    wire sda_low  = seq_sda | ((tx_low | ack_low) & ~(mst_r & (st_r inside {S_STA_H, S_IDLE})));
    // pending low keeps the clock down through the hold state
    wire scl_low  = st_r inside {S_HOLD, S_LOWP, S_STP_L};

    // read selection
    wire [7:0] st_byte = {mst_r, trx_r, busy_r, pend_r, lost_r, aas_r, 1'b0, lastb_r};
    wire [7:0] c2_byte = {mst_r, trx_r, busy_r, pend_r, imode_r, 3'h0};
    wire [7:0] rd_sel  = hit_c1 ? c1_r :
                         hit_c2 ? c2_byte :
                         hit_st ? st_byte :
                         hit_db ? sh_r :
                         hit_oa ? oa_r : 8'h00;

    // interface mode owns the pins, port mode passes port drive
    assign line_drv = imode_r ? {1'b0, scl_low, 1'b0, sda_low} : port_drv;
    assign transfer_interrupt = irq_r;

    // avalon handshake and read data
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            done_r       <= 1'b0;
            avs_readdata <= 32'h0000_0000;
        end else begin
            done_r <= req_any & ~done_r;
            if (avs_req.read & ~done_r) begin
                avs_readdata <= {24'h00_0000, rd_sel};
            end
        end
    end

    // two-flop synchronizers and edge history
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            scl_sync_r <= 2'h3;
            sda_sync_r <= 2'h3;
            scl_d_r    <= 1'b1;
            sda_d_r    <= 1'b1;
        end else begin
            scl_sync_r <= {scl_sync_r[0], clock_line_io_i};
            sda_sync_r <= {sda_sync_r[0], data_line_io_i};
            scl_d_r    <= scl_s;
            sda_d_r    <= sda_s;
        end
    end

    // mode, master and direction bits
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            imode_r <= 1'b0;
            mst_r   <= 1'b0;
            trx_r   <= 1'b0;
            arm_r   <= 1'b0;
        end else begin
            if (wr_c2) begin
                imode_r <= c2w.interface_mode_select;
            end
            if (c2_live) begin
                arm_r <= ~sreset & (c2w.soft_reset_field == SWR_ARM);
            end
            if (sreset | stop_det | lost_set) begin
                mst_r <= 1'b0;
            end else if (c2_live) begin
                mst_r <= c2w.master_select;
            end
            if (sreset | stop_det | lost_set) begin
                trx_r <= 1'b0;
            end else if (addr_hit) begin
                trx_r <= sda_s;
            end else if (mack) begin
                trx_r <= ~sh_r[0];
            end else if (c2_live) begin
                trx_r <= c2w.transmit_select;
            end
        end
    end

    // status flags; lost and slave sets win over clearing accesses, soft reset wins for busy and last bit
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busy_r  <= 1'b0;
            pend_r  <= PEND_RST;
            lost_r  <= 1'b0;
            aas_r   <= 1'b0;
            lastb_r <= 1'b0;
            irq_r   <= 1'b0;
        end else begin
            irq_r <= irq;
            if (sreset | stop_det) begin
                busy_r <= 1'b0;
            end else if (start_det) begin
                busy_r <= 1'b1;
            end
            if (sreset | pend_set) begin
                pend_r <= 1'b1;
            end else if (irq) begin
                pend_r <= 1'b0;
            end
            if (lost_set) begin
                lost_r <= 1'b1;
            end else if (sreset | wr_db | rd_db | wr_c2) begin
                lost_r <= 1'b0;
            end
            if (aas_set) begin
                aas_r <= 1'b1;
            end else if (sreset | wr_db | rd_db | start_det) begin
                aas_r <= 1'b0;
            end
            if (sreset) begin
                lastb_r <= 1'b0;
            end else if (scl_rise) begin
                lastb_r <= sda_s;
            end
        end
    end

    // control one and own address registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            c1_r <= CTRL_ONE_RST;
            oa_r <= {OWN_SA_RST, 1'b0};
        end else begin
            if (sreset) begin
                c1_r <= CTRL_ONE_RST;
            end else if (wr_c1) begin
                c1_r <= ctrl_one_t'(avs_req.writedata[7:0]);
            end else if (start_det) begin
                c1_r.bit_count <= 3'h0;
            end
            if (sreset) begin
                oa_r.own_slave_address <= OWN_SA_RST;
            end else if (wr_oa) begin
                oa_r <= own_addr_t'(avs_req.writedata[7:0]);
            end
        end
    end

    // shift register and bit position, shifting on falls keeps data stable while high
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sh_r    <= 8'h00;
            pos_r   <= 4'h0;
            first_r <= 1'b0;
        end else begin
            if (wr_db) begin
                sh_r <= avs_req.writedata[7:0];
            end else if (scl_fall & in_data) begin
                sh_r <= {sh_r[6:0], lastb_r};
            end
            if (sreset) begin
                pos_r   <= 4'h0;
                first_r <= 1'b0;
            end else if (start_det) begin
                pos_r   <= POS_BEFORE_BIT;
                first_r <= 1'b1;
            end else if (wend) begin
                pos_r   <= 4'h0;
                first_r <= 1'b0;
            end else if (scl_fall & busy_r) begin
                pos_r <= pos_r + 4'h1;
            end
        end
    end

    // line sequencer next state
    always_comb begin
        st_nxt  = st_r;
        cnt_nxt = cnt_r + 9'h001;
        case (st_r)
            S_IDLE: begin
                cnt_nxt = 9'h000;
                if (start_go) begin
                    st_nxt = S_STA_H;
                end
            end
            S_HOLD: begin
                cnt_nxt = 9'h000;
                if (pend_r) begin
                    st_nxt = S_LOWP;
                end
            end
            S_LOWP: begin
                if (lo_end) begin
                    cnt_nxt = 9'h000;
                    st_nxt  = (mst_r & ~lost_r) ? S_WAITH : S_IDLE;
                end
            end
            S_WAITH: begin
                cnt_nxt = 9'h000;
                if (scl_s) begin
                    st_nxt = S_HIGHP;
                end
            end
            S_HIGHP: begin
                if (~scl_s | hi_end) begin                 // clock sync with other masters
                    cnt_nxt = 9'h000;
                    st_nxt  = S_LOWP;
                end
            end
            S_STA_H: begin
                if (hi_end) begin
                    cnt_nxt = 9'h000;
                    st_nxt  = S_STA_L;
                end
            end
            S_STA_L: begin
                if (hi_end) begin
                    cnt_nxt = 9'h000;
                    st_nxt  = S_LOWP;
                end
            end
            S_STP_L: begin
                if (lo_end) begin
                    cnt_nxt = 9'h000;
                    st_nxt  = S_STP_W;
                end
            end
            S_STP_W: begin
                cnt_nxt = 9'h000;
                if (scl_s) begin
                    st_nxt = S_STP_H;
                end
            end
            S_STP_H: begin
                if (hi_end) begin
                    st_nxt = S_IDLE;
                end
            end
            default: begin
                st_nxt  = S_IDLE;
                cnt_nxt = 9'h000;
            end
        endcase
        if (sreset | ~imode_r) begin
            st_nxt  = S_IDLE;
            cnt_nxt = 9'h000;
        end else if (stop_go) begin
            st_nxt  = S_STP_L;
            cnt_nxt = 9'h000;
        end else if (irq & ~seq_sda) begin
            st_nxt  = S_HOLD;
        end else if (lost_set) begin
            st_nxt  = S_IDLE;
        end
    end

    // line sequencer state
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r  <= S_IDLE;
            cnt_r <= 9'h000;
        end else begin
            st_r  <= st_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence seq_irq_wait;
        irq && !pend_set ##1 !pend_r;
    endsequence
    sequence seq_release;
        $rose(pend_r) && (st_r == S_HOLD);
    endsequence
    AST_TX_SW: assert property ((c2_live && !trx_hw) |=> trx_r == $past(c2w.transmit_select))
        else $error("software direction write lost");
    AST_TX_SLAVE: assert property (addr_hit |=> trx_r == $past(sda_s))
        else $error("slave direction not loaded");
    AST_TX_MASTER: assert property ((mack && !lost_set) |=> trx_r != $past(sh_r[0]))
        else $error("master direction not inverted");
    AST_STOP_CLR: assert property (stop_det |=> !trx_r && !mst_r && !busy_r)
        else $error("stop did not clear mode bits");
    AST_NO_DETECT: assert property ((c1_r.address_detect_disable && !c2_live && !sreset
        && !stop_det && !lost_set) |=> $stable(trx_r))
        else $error("direction changed with detection off");
    AST_BUSY_SET: assert property ((start_det && !sreset) |=> busy_r)
        else $error("start did not set busy");
    AST_IRQ_OUT: assert property (irq |=> transfer_interrupt ##1 !transfer_interrupt)
        else $error("interrupt pulse wrong");
    AST_HOLD_LOW: assert property (seq_irq_wait |-> line_drv.scl_oe)
        else $error("clock not held while pending low");
    AST_LOW_REL: assert property (seq_release |-> line_drv.scl_oe[*8])
        else $error("clock released before low period");
    AST_PORT_LOCK: assert property ((wr_c2 && !imode_r) |=> $stable(mst_r) && $stable(pend_r))
        else $error("control write took effect in port mode");
    AST_SRESET: assert property (sreset |=> pend_r && !mst_r && (c1_r == CTRL_ONE_RST))
        else $error("soft reset incomplete");
    AST_ARB_LOST: assert property (lost_set |=> lost_r && !mst_r && !trx_r)
        else $error("arbitration loss not taken");
    AST_ARB_CLR: assert property (((rd_db || wr_db || wr_c2) && !lost_set) |=> !lost_r)
        else $error("lost flag not cleared");
    AST_AAS_CLR: assert property (((rd_db || wr_db) && !aas_set) |=> !aas_r)
        else $error("slave flag not cleared");
endmodule : i2c_bus_control_core

// ===== i2c_core_pkg.sv
// Purpose: shared offsets, layouts, timing and state types of the i2c bus control core
// Assumes: 8-bit registers, each in the low byte of an aligned 32-bit avalon word
// Notes: serial clock counts are in system clock cycles
// Notes on behaviour
// - software bit chooses transmitter or receiver
// - slave loads direction from received address
// - master inverts sent direction after acknowledge
// - stop or arbitration loss clears direction
// - address detect disabled leaves direction alone
// - free format never decodes direction
// - single control write generates start condition
// - control write starts stop, waits stretch
// - busy follows detected start and stop
// - master interrupt after counted word clocks
// - addressed slave interrupts after every word
// - interrupt clears pending, clock held low
// - data write sets pending, releases later
// - mode bit routes pins to interface
// - port mode ignores other control writes
// - two-step soft reset reinitializes interface
// - compare data line at clock rise
// - lost master becomes slave, releases lines
// - data access or control write clears lost
// - own address or general call flags slave
// - free format flags first word, access clears
// - clock select sets high and low counts
// - master bit cleared by stop or loss
package i2c_core_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL_ONE = 8'h00;
    localparam logic [7:0] OFS_CTRL_TWO = 8'h04;
    localparam logic [7:0] OFS_STATUS   = 8'h08;
    localparam logic [7:0] OFS_DATA_BUF = 8'h0C;
    localparam logic [7:0] OFS_OWN_ADDR = 8'h10;
    // serial clock: high = base + (step << select), low = high + extra
    localparam logic [8:0] CLK_HIGH_BASE = 9'h007;
    localparam logic [8:0] CLK_STEP      = 9'h002;
    localparam logic [8:0] CLK_LOW_EXTRA = 9'h003;
    // word lengths
    localparam logic [3:0] ADDR_WORD_BITS = 4'h8;
    localparam logic [3:0] POS_BEFORE_BIT = 4'hF;
    localparam logic [3:0] POS_ADDR_LAST  = 4'h7;
    localparam logic [7:0] GEN_CALL_CODE  = 8'h00;
    // soft reset sequence codes
    localparam logic [1:0] SWR_ARM  = 2'h2;
    localparam logic [1:0] SWR_FIRE = 2'h1;
    // control one layout
    typedef struct packed {
        logic [2:0] bit_count;
        logic       handshake_slot_enable;
        logic       address_detect_disable;
        logic [2:0] clock_period_select;
    } ctrl_one_t;
    // control two layout (bit 2 reserved)
    typedef struct packed {
        logic       master_select;
        logic       transmit_select;
        logic       bus_busy;
        logic       pending_flag;
        logic       interface_mode_select;
        logic       reserved_bit;
        logic [1:0] soft_reset_field;
    } ctrl_two_t;
    // own address layout
    typedef struct packed {
        logic [6:0] own_slave_address;
        logic       free_format_select;
    } own_addr_t;
    // open-drain drive of both lines
    typedef struct packed {
        logic scl_o;
        logic scl_oe;
        logic sda_o;
        logic sda_oe;
    } pin_drv_t;
    // avalon request group
    typedef struct packed {
        logic [7:0]  address;
        logic        read;
        logic        write;
        logic [31:0] writedata;
    } avs_req_t;
    // line sequencer states
    typedef enum logic [3:0] {
        S_IDLE, S_HOLD, S_LOWP, S_WAITH, S_HIGHP,
        S_STA_H, S_STA_L, S_STP_L, S_STP_W, S_STP_H
    } link_state_t;
    // reset values
    localparam ctrl_one_t  CTRL_ONE_RST = 8'h00;
    localparam logic [6:0] OWN_SA_RST   = 7'h00;
    localparam logic       PEND_RST     = 1'b1;
endpackage : i2c_core_pkg

// ===== i2c_slave_model.sv
// Purpose: far-side slave that acknowledges one address and its data words
// Assumes: lines resolved with pull-ups by the bench
// Notes: receive only, never stretches the clock
`timescale 1ns/1ns
module i2c_slave_model #(
    parameter logic [6:0] ADDR = 7'h3C
) (
    input  wire logic scl,
    input  wire logic sda,
    output logic      sda_oe
);
    logic [7:0] sh;    // shifted word
    int         cnt;   // clock rises in word
    logic       first; // address word pending
    logic       hit;   // address matched
    initial sda_oe = 0;
    initial cnt = 0;
    initial first = 0;
    initial hit = 0;
    // start: next word is the address
    always @(negedge sda) if (scl) begin
        cnt = 0;
        first = 1;
    end
    // stop ends the selection
    always @(posedge sda) if (scl) hit = 0;
    // sample at clock rise
    always @(posedge scl) begin
        sh = {sh[6:0], sda};
        cnt = cnt + 1;
    end
    // acknowledge slot after eight bits
    always @(negedge scl) begin
        if (cnt == 8 && first) hit = (sh[7:1] == ADDR);
        if (cnt == 8) sda_oe = hit;
        if (cnt >= 9) begin
            sda_oe = 0;
            cnt = 0;
            first = 0;
        end
    end
endmodule : i2c_slave_model

// ===== i2c_bus_control_core_tb_top.sv
// Purpose: self-checking bench of the i2c bus control core
// Assumes: lines pulled up, wired with the far-side slave
// Notes: reads checked against a queue of expected bytes
`timescale 1ns/1ns
module i2c_bus_control_core_tb_top;
    import i2c_core_pkg::*;
    logic        clk = 0, rst = 1, bm_scl = 1, bm_sda = 1; // bench master, 1 = released
    logic        wait_r, irq, p_oe;
    logic [31:0] rdata;
    avs_req_t    req = '0;
    pin_drv_t    drv, pdrv = '0;
    logic [7:0]  q[$];        // expected read data
    logic [7:0]  rnd = 8'h23; // lfsr state
    logic [8:0]  sb = 9'h143; // address A1 then released ack
    int          n_fail = 0, compares = 0;
    wire scl_w = (drv.scl_oe ? drv.scl_o : 1'b1) & bm_scl;
    wire sda_w = (drv.sda_oe ? drv.sda_o : 1'b1) & bm_sda & ~p_oe;
    always #20 clk = ~clk;
    i2c_bus_control_core dut (.clk(clk), .rst(rst), .avs_req(req), .avs_readdata(rdata),
        .avs_waitrequest(wait_r), .clock_line_io_i(scl_w), .data_line_io_i(sda_w),
        .line_drv(drv), .port_drv(pdrv), .transfer_interrupt(irq));
    i2c_slave_model slv (.scl(scl_w), .sda(sda_w), .sda_oe(p_oe));
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // read results taken off the queue
    always @(negedge clk) if (req.read && wait_r === 1'b0) chk("readdata", q.pop_front(), rdata[7:0]);
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        logic ok;
        ok = 0;
        req <= '{address: a, read: !w, write: w, writedata: {24'h0, d}};
        while (!ok) begin
            @(negedge clk) ok = (wait_r === 1'b0);
            @(posedge clk);
        end
        req.read <= 0;
        req.write <= 0;
        @(posedge clk);
    endtask : acc
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        q.push_back(e);
        acc(0, a, 8'h00);
    endtask : rd
    task automatic wirq;
        while (irq !== 1'b1) @(negedge clk);
        chk("interrupt", 8'h01, {7'h0, irq});
        @(posedge clk);
    endtask : wirq
    task automatic wlines(input logic need_sda);
        while (!(scl_w && (sda_w || !need_sda))) @(posedge clk);
    endtask : wlines
    task automatic mstart(input logic [7:0] ab, input logic [7:0] st);
        acc(1, OFS_DATA_BUF, ab);
        acc(1, OFS_CTRL_TWO, 8'hF8);
        wirq();
        rd(OFS_STATUS, st);
    endtask : mstart
    task automatic mstop;
        acc(1, OFS_CTRL_TWO, 8'hD8);
        wlines(1);
        repeat (4) @(posedge clk);
        rd(OFS_CTRL_TWO, 8'h18);
    endtask : mstop
    task automatic print_verdict;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : print_verdict
    initial begin
        #2000000;
        n_fail++;
        print_verdict();
    end
    initial begin
        repeat (4) @(posedge clk);
        rst <= 0;
        @(posedge clk);
        rd(OFS_CTRL_TWO, 8'h10);
        rd(8'h14, 8'h00);
        acc(1, OFS_CTRL_TWO, 8'hE0);
        rd(OFS_CTRL_TWO, 8'h10);
        repeat (4) begin
            rnd = lfsr(rnd);
            @(posedge clk) pdrv <= pin_drv_t'(rnd[3:0]);
            @(negedge clk) chk("port", {4'h0, pdrv}, {4'h0, drv});
        end
        @(posedge clk) pdrv <= '0;
        @(posedge clk);
        chk("lines", 8'h03, {6'h0, scl_w, sda_w});
        acc(1, OFS_CTRL_TWO, 8'h18);
        acc(1, OFS_CTRL_TWO, 8'h58);
        rd(OFS_CTRL_TWO, 8'h58);
        acc(1, OFS_CTRL_TWO, 8'h18);
        acc(1, OFS_CTRL_ONE, 8'h10);
        acc(1, OFS_OWN_ADDR, 8'hA0);
        $display("test registers done");
        mstart(8'h78, 8'hE0);
        chk("scl_hold", 8'h01, {7'h0, drv.scl_oe});
        acc(1, OFS_DATA_BUF, rnd);
        wirq();
        rd(OFS_STATUS, 8'hE0);
        mstop();
        mstart(8'h45, 8'hE1);
        mstop();
        mstart(8'h79, 8'hA0);
        mstop();
        $display("test master done");
        bm_sda <= 0;
        repeat (4) @(posedge clk);
        bm_scl <= 0;
        for (int i = 8; i >= 0; i--) begin
            @(posedge clk) bm_sda <= sb[i];
            repeat (4) @(posedge clk);
            bm_scl <= 1;
            repeat (3) @(posedge clk);
            if (i == 0) chk("ack", 8'h00, {7'h0, sda_w});
            bm_scl <= 0;
        end
        wirq();
        rd(OFS_STATUS, 8'h64);
        rd(OFS_DATA_BUF, 8'hA1);
        rd(OFS_STATUS, 8'h60);
        acc(1, OFS_DATA_BUF, 8'hFF);
        bm_sda <= 0;
        bm_scl <= 1;
        wlines(0);
        repeat (3) @(posedge clk);
        bm_sda <= 1;
        repeat (4) @(posedge clk);
        rd(OFS_CTRL_TWO, 8'h18);
        $display("test slave done");
        acc(1, OFS_CTRL_ONE, 8'h1D);
        acc(1, OFS_CTRL_TWO, 8'h1A);
        acc(1, OFS_CTRL_TWO, 8'h19);
        rd(OFS_CTRL_ONE, 8'h00);
        rd(OFS_OWN_ADDR, 8'h00);
        rd(OFS_CTRL_TWO, 8'h18);
        $display("test soft reset done");
        print_verdict();
    end
endmodule : i2c_bus_control_core_tb_top
